// ### core/power_rail_command_handler.sv
// Command handler of a digitally controlled power rail
// Assumes a framing layer that delivers decoded commands on the i_clk domain
`timescale 1ns/1ns

module power_rail_command_handler
   import rail_cmd_pkg::*;
#(
   parameter int STORE_CYCLES = STORE_WAIT_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Command transactions
   input wire cmd_req_t i_cmd,
   output rsp_t o_rsp,
   output logic o_busy,
   // Pins
   input wire logic i_enable_pin,
   input wire logic [1:0] i_margin_select_pin,
   input wire logic [15:0] i_strap_vout,
   output logic o_smbus_alert_output,
   // Power stage
   input wire logic [7:0] i_fault_cond,
   output logic o_run,
   output logic o_off_immediate,
   output logic [1:0] o_margin_state,
   output logic [15:0] o_vout_target,
   output logic [15:0] o_vout_ceiling
);

   localparam int CNT_W = $clog2(STORE_CYCLES + 1);

   typedef struct packed {
      phase_t phase;
      logic [CNT_W-1:0] cnt;
      settings_t cfg;
      settings_t dirty;
      settings_t wr_mask;
      logic def_wr;
      logic user_wr;
      logic [1:0] en_s;
      logic [1:0] mgn_s1;
      logic [1:0] mgn_s2;
      logic [15:0] strap_s1;
      logic [15:0] strap_s2;
      logic [15:0] strap;
      logic [15:0] ceil_active;
      logic [7:0] fault;
      logic [7:0] security;
      logic shutdown;
      logic run;
      logic off_hard;
      logic [1:0] margin;
      logic alert;
      logic busy;
      rsp_t rsp;
   } state_t;

   state_t st;
   state_t next_st;
   settings_t def_rd;
   settings_t def_pres;
   settings_t user_rd;
   settings_t user_pres;
   logic pin_on;
   logic cmd_on;
   logic want;
   logic clear;
   logic [15:0] limit;

   // ************************************************
   // Helpers
   // ************************************************
   function automatic logic [15:0] strap_limit(input logic [15:0] v);
      logic [19:0] p;
      p = (20'(v) * 20'(CEIL_NUM)) / 20'(CEIL_DEN);
      return (p[19:16] != 4'h0) ? 16'hFFFF : p[15:0];
   endfunction

   function automatic logic op_legal(input logic [7:0] b);
      logic [1:0] r;
      logic [1:0] m;
      r = b[RUN_LSB+1:RUN_LSB];
      m = b[MGN_LSB+1:MGN_LSB];
      return (b[3:0] == 4'h0) && (((r == RUN_IMM_OFF || r == RUN_SOFT_OFF) && m == MARGIN_NOM)
         || (r == RUN_ON && (m == MARGIN_NOM || m == MARGIN_LOW || m == MARGIN_HIGH)));
   endfunction

   function automatic settings_t merge(input settings_t cur, input settings_t d, input settings_t p);
      return (cur & ~p) | (d & p);
   endfunction

   // ************************************************
   // Stores
   // ************************************************
   nv_settings_store #(.W(SET_W)) u_default_store (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_wr(st.def_wr),
      .i_wr_mask(st.wr_mask),
      .i_wr_data(st.cfg),
      .o_rd_data(def_rd),
      .o_rd_present(def_pres)
   );

   nv_settings_store #(.W(SET_W)) u_user_store (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_wr(st.user_wr),
      .i_wr_mask(st.wr_mask),
      .i_wr_data(st.cfg),
      .o_rd_data(user_rd),
      .o_rd_present(user_pres)
   );

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      next_st = st;
      clear = 1'b0;
      want = 1'b0;
      limit = 16'h0000;
      next_st.rsp = '0;
      next_st.def_wr = 1'b0;
      next_st.user_wr = 1'b0;
      // Pins pass two flops before use
      next_st.en_s = {st.en_s[0], i_enable_pin};
      next_st.mgn_s1 = i_margin_select_pin;
      next_st.mgn_s2 = st.mgn_s1;
      next_st.strap_s1 = i_strap_vout;
      next_st.strap_s2 = st.strap_s1;
      case (st.phase)
         PH_BOOT: begin
            // Wait until the strap has crossed the synchroniser
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt == CNT_W'(BOOT_SYNC_CYCLES)) begin
               next_st.cnt = '0;
               next_st.strap = st.strap_s2;
               next_st.cfg.run_margin = RUN_MARGIN_RESET;
               next_st.cfg.on_src = ON_SRC_RESET;
               next_st.cfg.setpoint = st.strap_s2;
               next_st.cfg.ceiling = strap_limit(st.strap_s2);
               next_st.phase = PH_LOAD_DEF;
            end
         end
         PH_LOAD_DEF: begin
            next_st.cfg = merge(st.cfg, def_rd, def_pres);
            next_st.phase = PH_LOAD_USER;
         end
         PH_LOAD_USER: begin
            next_st.cfg = merge(st.cfg, user_rd, user_pres);
            next_st.security = SECURITY_AFTER_RESTORE;
            next_st.dirty = '0;
            next_st.phase = PH_IDLE;
         end
         PH_STORE: begin
            // Commands arriving now get no answer at all
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt == CNT_W'(STORE_CYCLES - 1)) begin
               next_st.cnt = '0;
               next_st.phase = PH_IDLE;
            end
         end
         PH_IDLE: begin
            if (i_cmd.valid) begin
               next_st.rsp.valid = 1'b1;
               case (i_cmd.kind)
                  CMD_READ: begin
                     case (i_cmd.code)
                        CODE_RUN_MARGIN: next_st.rsp.data = {8'h00, st.cfg.run_margin};
                        CODE_ON_SRC: next_st.rsp.data = {8'h00, st.cfg.on_src};
                        CODE_VOUT_FORMAT: next_st.rsp.data = {8'h00, VOUT_FORMAT_VALUE};
                        CODE_VOUT_SET: next_st.rsp.data = st.cfg.setpoint;
                        CODE_VOUT_CEIL: next_st.rsp.data = st.cfg.ceiling;
                        CODE_FAULT_STATUS: next_st.rsp.data = {8'h00, st.fault};
                        CODE_SECURITY: next_st.rsp.data = {8'h00, st.security};
                        default: next_st.rsp.err = 1'b1;
                     endcase
                  end
                  CMD_WR_BYTE, CMD_WR_WORD: begin
                     case (i_cmd.code)
                        CODE_RUN_MARGIN: begin
                           if (op_legal(i_cmd.data[7:0])) begin
                              next_st.cfg.run_margin = i_cmd.data[7:0];
                              next_st.dirty.run_margin = '1;
                           end else begin
                              next_st.rsp.err = 1'b1;
                           end
                        end
                        CODE_ON_SRC: begin
                           next_st.cfg.on_src = i_cmd.data[7:0];
                           next_st.dirty.on_src = '1;
                        end
                        CODE_VOUT_SET: begin
                           next_st.cfg.setpoint = i_cmd.data;
                           next_st.dirty.setpoint = '1;
                        end
                        CODE_VOUT_CEIL: begin
                           next_st.cfg.ceiling = i_cmd.data;
                           next_st.dirty.ceiling = '1;
                        end
                        default: next_st.rsp.err = 1'b1;
                     endcase
                  end
                  CMD_SEND: begin
                     case (i_cmd.code)
                        CODE_CLEAR_FAULTS: clear = 1'b1;
                        CODE_STORE_DEFAULT: begin
                           next_st.def_wr = 1'b1;
                           next_st.wr_mask = st.dirty;
                           next_st.phase = PH_STORE;
                        end
                        CODE_STORE_USER: begin
                           next_st.user_wr = 1'b1;
                           next_st.wr_mask = '1;
                           next_st.phase = PH_STORE;
                        end
                        CODE_RESTORE_DEFAULT: begin
                           next_st.cfg = merge(st.cfg, def_rd, def_pres);
                           next_st.dirty = '0;
                           next_st.security = SECURITY_AFTER_RESTORE;
                        end
                        CODE_RESTORE_USER: begin
                           next_st.cfg = merge(st.cfg, user_rd, user_pres);
                           next_st.dirty = '0;
                           next_st.security = SECURITY_AFTER_RESTORE;
                        end
                        default: next_st.rsp.err = 1'b1;
                     endcase
                  end
                  default: next_st.rsp.err = 1'b1;
               endcase
            end
         end
         default: next_st.phase = PH_BOOT;
      endcase

      // Enable decode
      pin_on = (st.en_s[1] == st.cfg.on_src[ON_POL_BIT]);
      cmd_on = (st.cfg.run_margin[RUN_LSB+1:RUN_LSB] == RUN_ON);
      case (st.cfg.on_src[SRC_LSB+2:SRC_LSB])
         SRC_ALWAYS: want = 1'b1;
         SRC_PIN: want = pin_on;
         SRC_CMD: want = cmd_on;
         SRC_BOTH: want = pin_on && cmd_on;
         default: want = 1'b0;
      endcase
      if (st.phase != PH_IDLE && st.phase != PH_STORE) begin
         want = 1'b0;
      end

      // Set wins over clear, so a live fault reappears at once
      next_st.fault = (clear ? 8'h00 : st.fault) | i_fault_cond;
      next_st.alert = |next_st.fault;
      // Shutdown latch is released only by dropping the on request
      if (st.run && (|i_fault_cond)) begin
         next_st.shutdown = 1'b1;
      end else if (!want) begin
         next_st.shutdown = 1'b0;
      end
      next_st.run = want && !next_st.shutdown;
      if (st.run && !next_st.run) begin
         if (next_st.shutdown) begin
            next_st.off_hard = 1'b1;
         end else if (!cmd_on && (st.cfg.on_src[SRC_LSB+2:SRC_LSB] == SRC_CMD
               || st.cfg.on_src[SRC_LSB+2:SRC_LSB] == SRC_BOTH)) begin
            next_st.off_hard = (st.cfg.run_margin[RUN_LSB+1:RUN_LSB] == RUN_IMM_OFF);
         end else begin
            next_st.off_hard = st.cfg.on_src[ON_HARD_BIT];
         end
      end
      if (!st.run && next_st.run) begin
         next_st.ceil_active = next_st.cfg.ceiling;
      end
      // Pin margin overrides the commanded one
      next_st.margin = (st.mgn_s2 == MARGIN_NOM) ? st.cfg.run_margin[MGN_LSB+1:MGN_LSB] : st.mgn_s2;

      // Clamp against the lower of both limits
      limit = strap_limit(next_st.strap);
      if (next_st.cfg.ceiling < limit) begin
         limit = next_st.cfg.ceiling;
      end
      if (next_st.cfg.setpoint > limit) begin
         next_st.cfg.setpoint = limit;
      end
      next_st.busy = (next_st.phase != PH_IDLE);
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= '0;
         st.cfg.on_src <= ON_SRC_RESET;
         st.cfg.run_margin <= RUN_MARGIN_RESET;
         st.security <= SECURITY_RESET;
         st.busy <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign o_rsp = st.rsp;
   assign o_busy = st.busy;
   assign o_smbus_alert_output = st.alert;
   assign o_run = st.run;
   assign o_off_immediate = st.off_hard;
   assign o_margin_state = st.margin;
   assign o_vout_target = st.cfg.setpoint;
   assign o_vout_ceiling = st.ceil_active;

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   logic idle_cmd;
   assign idle_cmd = i_cmd.valid && (st.phase == PH_IDLE);

   property p_fmt_read;
      idle_cmd && i_cmd.kind == CMD_READ && i_cmd.code == CODE_VOUT_FORMAT
         |=> o_rsp.valid && o_rsp.data == 16'h0013 && !o_rsp.err;
   endproperty
   a_fmt_read: assert property (p_fmt_read) else $error("format byte not 13h");

   property p_read_any;
      idle_cmd && i_cmd.kind == CMD_READ |=> o_rsp.valid ##1 !o_rsp.valid;
   endproperty
   a_read_any: assert property (p_read_any) else $error("read not answered");

   property p_clamp;
      st.phase == PH_IDLE |-> st.cfg.setpoint <= st.cfg.ceiling && st.cfg.setpoint <= strap_limit(st.strap);
   endproperty
   a_clamp: assert property (p_clamp) else $error("setpoint above limit");

   property p_clear;
      idle_cmd && i_cmd.kind == CMD_SEND && i_cmd.code == CODE_CLEAR_FAULTS
         |=> st.fault == $past(i_fault_cond) && o_smbus_alert_output == (|$past(i_fault_cond));
   endproperty
   a_clear: assert property (p_clear) else $error("fault clear wrong");

   property p_bad_op;
      idle_cmd && (i_cmd.kind == CMD_WR_BYTE || i_cmd.kind == CMD_WR_WORD)
         && i_cmd.code == CODE_RUN_MARGIN && !op_legal(i_cmd.data[7:0])
         |=> o_rsp.err && $stable(st.cfg.run_margin);
   endproperty
   a_bad_op: assert property (p_bad_op) else $error("bad run byte accepted");

   property p_store_busy;
      idle_cmd && i_cmd.kind == CMD_SEND && i_cmd.code == CODE_STORE_USER |=> o_busy [*8];
   endproperty
   a_store_busy: assert property (p_store_busy) else $error("store not busy");

   property p_restore_sec;
      idle_cmd && i_cmd.kind == CMD_SEND && i_cmd.code == CODE_RESTORE_DEFAULT
         |=> st.security == SECURITY_AFTER_RESTORE ##1 st.security == SECURITY_AFTER_RESTORE;
   endproperty
   a_restore_sec: assert property (p_restore_sec) else $error("security not level 1");

   property p_start_cmd;
      st.phase == PH_IDLE && st.cfg.on_src[SRC_LSB+2:SRC_LSB] == SRC_CMD
         && st.cfg.run_margin[RUN_LSB+1:RUN_LSB] == RUN_ON && !st.run && !st.shutdown |=> o_run;
   endproperty
   a_start_cmd: assert property (p_start_cmd) else $error("command start missed");

   property p_pin_pol;
      st.phase == PH_IDLE && st.cfg.on_src[SRC_LSB+2:SRC_LSB] == SRC_PIN
         && st.en_s[1] == st.cfg.on_src[ON_POL_BIT] && !st.run && !st.shutdown |=> o_run;
   endproperty
   a_pin_pol: assert property (p_pin_pol) else $error("pin start missed");

   property p_margin_pin;
      st.mgn_s2 != MARGIN_NOM |=> o_margin_state == $past(st.mgn_s2);
   endproperty
   a_margin_pin: assert property (p_margin_pin) else $error("margin pin ignored");

   c_store_user: cover property (idle_cmd && i_cmd.kind == CMD_SEND && i_cmd.code == CODE_STORE_USER);
   c_restore_user: cover property (idle_cmd && i_cmd.kind == CMD_SEND && i_cmd.code == CODE_RESTORE_USER);
   c_margin_high: cover property (o_run && o_margin_state == MARGIN_HIGH);
   c_fault_off: cover property (o_run ##1 !o_run && o_off_immediate);

endmodule

// ### core/rail_cmd_pkg.sv
// Shared constants and carriers for the power rail command handler
// Assumes a framing layer that delivers one decoded command per valid cycle
package rail_cmd_pkg;

   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int STORE_WAIT_MS = 20;
   localparam int STORE_WAIT_CYCLES = STORE_WAIT_MS * (CLK_HZ / 1000);
   localparam int BOOT_SYNC_CYCLES = 2;

   // ************************************************
   // Command codes
   // ************************************************
   localparam logic [7:0] CODE_RUN_MARGIN = 8'h01;
   localparam logic [7:0] CODE_ON_SRC = 8'h02;
   localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CODE_STORE_DEFAULT = 8'h11;
   localparam logic [7:0] CODE_RESTORE_DEFAULT = 8'h12;
   localparam logic [7:0] CODE_STORE_USER = 8'h15;
   localparam logic [7:0] CODE_RESTORE_USER = 8'h16;
   localparam logic [7:0] CODE_VOUT_FORMAT = 8'h20;
   localparam logic [7:0] CODE_VOUT_SET = 8'h21;
   localparam logic [7:0] CODE_VOUT_CEIL = 8'h24;
   localparam logic [7:0] CODE_FAULT_STATUS = 8'h78;
   localparam logic [7:0] CODE_SECURITY = 8'hFA;

   // ************************************************
   // Field positions and encodings
   // ************************************************
   localparam int RUN_LSB = 6;
   localparam int MGN_LSB = 4;
   localparam int SRC_LSB = 2;
   localparam int ON_POL_BIT = 1;
   localparam int ON_HARD_BIT = 0;
   localparam logic [1:0] RUN_IMM_OFF = 2'h0;
   localparam logic [1:0] RUN_SOFT_OFF = 2'h1;
   localparam logic [1:0] RUN_ON = 2'h2;
   localparam logic [1:0] MARGIN_NOM = 2'h0;
   localparam logic [1:0] MARGIN_LOW = 2'h1;
   localparam logic [1:0] MARGIN_HIGH = 2'h2;
   localparam logic [2:0] SRC_ALWAYS = 3'h0;
   localparam logic [2:0] SRC_PIN = 3'h5;
   localparam logic [2:0] SRC_CMD = 3'h6;
   localparam logic [2:0] SRC_BOTH = 3'h7;

   // ************************************************
   // Reset and fixed values
   // ************************************************
   localparam logic [7:0] RUN_MARGIN_RESET = 8'h00;
   localparam logic [7:0] ON_SRC_RESET = 8'h16;
   localparam logic [7:0] VOUT_FORMAT_VALUE = 8'h13;
   localparam logic [7:0] SECURITY_RESET = 8'h00;
   localparam logic [7:0] SECURITY_AFTER_RESTORE = 8'h01;
   localparam logic [3:0] CEIL_NUM = 4'hB;
   localparam logic [3:0] CEIL_DEN = 4'hA;

   // ************************************************
   // Types
   // ************************************************
   typedef enum logic [1:0] {CMD_SEND, CMD_WR_BYTE, CMD_WR_WORD, CMD_READ} cmd_kind_t;
   typedef enum logic [2:0] {PH_BOOT, PH_LOAD_DEF, PH_LOAD_USER, PH_IDLE, PH_STORE} phase_t;

   typedef struct packed {
      logic valid;
      cmd_kind_t kind;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_req_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [15:0] data;
   } rsp_t;

   typedef struct packed {
      logic [7:0] run_margin;
      logic [7:0] on_src;
      logic [15:0] ceiling;
      logic [15:0] setpoint;
   } settings_t;

   localparam int SET_W = $bits(settings_t);

endpackage

// ### core/nv_settings_store.sv
// Settings store with per-bit presence, registered read port
// Assumes writes are rare pulses from the command handler on the same clock
`timescale 1ns/1ns

module nv_settings_store #(
   parameter int W = 48
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Write side
   input wire logic i_wr,
   input wire logic [W-1:0] i_wr_mask,
   input wire logic [W-1:0] i_wr_data,
   // Read side
   output logic [W-1:0] o_rd_data,
   output logic [W-1:0] o_rd_present
);

   typedef struct packed {
      logic [W-1:0] mem;
      logic [W-1:0] present;
      logic [W-1:0] rd_data;
      logic [W-1:0] rd_present;
   } store_t;

   store_t st;
   store_t next_st;

   // ************************************************
   // Storage
   // ************************************************
   // Reset stands for first power-up with a blank store
   always_comb begin
      next_st = st;
      if (i_wr) begin
         next_st.mem = (st.mem & ~i_wr_mask) | (i_wr_data & i_wr_mask);
         next_st.present = st.present | i_wr_mask;
      end
      next_st.rd_data = st.mem;
      next_st.rd_present = st.present;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_rd_data = st.rd_data;
   assign o_rd_present = st.rd_present;

endmodule

// ### bench/host_cmd_model.sv
// Host model that issues one command at a time and paces them
// Assumes the handler answers one cycle after it takes a command
`timescale 1ns/1ns

module host_cmd_model
   import rail_cmd_pkg::*;
#(
   parameter int GAP = 4
) (
   // Clock
   input wire logic i_clk,
   // Command port
   output cmd_req_t o_cmd,
   input wire rsp_t i_rsp,
   input wire logic i_busy
);
   initial begin
      o_cmd = '0;
   end

   task automatic xfer(input cmd_kind_t kind, input logic [7:0] code, input logic [15:0] data, output rsp_t rsp);
      int n;
      n = 0;
      @(negedge i_clk);
      while (i_busy !== 1'b0 && n < 200) begin
         @(negedge i_clk);
         n++;
      end
      o_cmd = '{valid: 1'b1, kind: kind, code: code, data: data};
      @(negedge i_clk);
      rsp = i_rsp;
      // Released code and data lines show the inverse, never a stale copy
      o_cmd = '{valid: 1'b0, kind: kind, code: ~code, data: ~data};
      repeat (GAP) @(negedge i_clk);
   endtask
endmodule

// ### bench/test_power_rail_command_handler.sv
// Testbench for the power rail command handler
// Assumes the host model paces commands; store wait shortened to 16 cycles
`timescale 1ns/1ns

module test_power_rail_command_handler
   import rail_cmd_pkg::*;
();
   localparam logic [15:0] STRAP = 16'h2000;
   logic clk, rst, en, busy, alert, run, offi;
   logic [1:0] sel, marg;
   logic [7:0] flt;
   logic [15:0] tgt, ceil, lim;
   cmd_req_t cmd;
   rsp_t rsp, r;
   int failures, checked;
   logic [7:0] ops [4] = '{8'h80, 8'h40, 8'h80, 8'h00};
   logic [7:0] cfgs [3] = '{8'h17, 8'h16, 8'h15};

   power_rail_command_handler #(.STORE_CYCLES(16)) dut (.i_clk(clk), .i_sys_rst(rst), .i_cmd(cmd), .o_rsp(rsp),
      .o_busy(busy), .i_enable_pin(en), .i_margin_select_pin(sel), .i_strap_vout(STRAP),
      .o_smbus_alert_output(alert), .i_fault_cond(flt), .o_run(run), .o_off_immediate(offi),
      .o_margin_state(marg), .o_vout_target(tgt), .o_vout_ceiling(ceil));
   host_cmd_model #(.GAP(4)) host (.i_clk(clk), .o_cmd(cmd), .i_rsp(rsp), .i_busy(busy));

   // ************************************************
   // Access and compare tasks
   // ************************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      host.xfer(code < 8'h20 ? CMD_WR_BYTE : CMD_WR_WORD, code, data, r);
   endtask
   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      host.xfer(CMD_READ, code, 16'h0000, r);
      chk("read valid", 16'h0001, {15'h0, r.valid});
      chk($sformatf("read %h", code), exp, r.data);
   endtask
   task automatic snd(input logic [7:0] code);
      host.xfer(CMD_SEND, code, 16'h0000, r);
   endtask
   task automatic results();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ************************************************
   // Clock, watchdog and tests
   // ************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      // Tests need a few hundred cycles; this allows about 50,000
      #2000000;
      failures++;
      results();
   end
   initial begin
      rst = 1'b1;
      en = 1'b0;
      sel = 2'h0;
      flt = 8'h00;
      failures = 0;
      checked = 0;
      lim = 16'((32'(STRAP) * 11) / 10);
      repeat (16) @(negedge clk);
      rst = 1'b0;
      rd(CODE_ON_SRC, 16'h0016);
      rd(CODE_VOUT_FORMAT, 16'h0013);
      host.xfer(CMD_READ, 8'h55, 16'h0000, r);
      chk("unmapped err", 16'h0001, {15'h0, r.err});
      $display("test defaults done");
      wr(CODE_ON_SRC, 16'h001A);
      foreach (ops[i]) begin
         wr(CODE_RUN_MARGIN, {8'h00, ops[i]});
         chk("run by command", {15'h0, ops[i][7]}, {15'h0, run});
      end
      sel = 2'h1;
      wr(CODE_RUN_MARGIN, 16'h00A0);
      chk("pin margin", 16'h0001, {14'h0, marg});
      sel = 2'h0;
      rd(CODE_RUN_MARGIN, 16'h00A0);
      chk("cmd margin", 16'h0002, {14'h0, marg});
      host.xfer(CMD_WR_BYTE, CODE_RUN_MARGIN, 16'h0081, r);
      chk("bad byte err", 16'h0001, {15'h0, r.err});
      rd(CODE_RUN_MARGIN, 16'h00A0);
      wr(CODE_RUN_MARGIN, 16'h0000);
      $display("test command control done");
      foreach (cfgs[i]) begin
         wr(CODE_ON_SRC, {8'h00, cfgs[i]});
         en = cfgs[i][1];
         rd(CODE_ON_SRC, {8'h00, cfgs[i]});
         chk("pin start", 16'h0001, {15'h0, run});
         en = ~cfgs[i][1];
         rd(CODE_ON_SRC, {8'h00, cfgs[i]});
         chk("pin stop", 16'h0000, {15'h0, run});
         chk("stop style", {15'h0, cfgs[i][0]}, {15'h0, offi});
      end
      wr(CODE_ON_SRC, 16'h001E);
      chk("both needs command", 16'h0000, {15'h0, run});
      wr(CODE_RUN_MARGIN, 16'h0090);
      chk("both start", 16'h0001, {15'h0, run});
      chk("cmd margin low", 16'h0001, {14'h0, marg});
      wr(CODE_ON_SRC, 16'h0000);
      wr(CODE_RUN_MARGIN, 16'h0000);
      chk("always on", 16'h0001, {15'h0, run});
      wr(CODE_ON_SRC, {8'h00, cfgs[2]});
      chk("pin off again", 16'h0000, {15'h0, run});
      $display("test enable pin done");
      en = 1'b0;
      rd(CODE_VOUT_FORMAT, 16'h0013);
      flt = 8'h04;
      rd(CODE_FAULT_STATUS, 16'h0004);
      chk("alert", 16'h0001, {15'h0, alert});
      flt = 8'h00;
      snd(CODE_CLEAR_FAULTS);
      chk("alert clear", 16'h0000, {15'h0, alert});
      chk("no restart", 16'h0000, {15'h0, run});
      flt = 8'h01;
      snd(CODE_CLEAR_FAULTS);
      rd(CODE_FAULT_STATUS, 16'h0001);
      chk("alert again", 16'h0001, {15'h0, alert});
      flt = 8'h00;
      snd(CODE_CLEAR_FAULTS);
      en = 1'b1;
      $display("test faults done");
      wr(CODE_VOUT_SET, 16'hFFFF);
      chk("clamp strap", lim, tgt);
      wr(CODE_VOUT_CEIL, 16'h2100);
      chk("clamp ceiling", 16'h2100, tgt);
      wr(CODE_VOUT_SET, 16'h1000);
      rd(CODE_VOUT_SET, 16'h1000);
      chk("ceiling held", lim, ceil);
      en = 1'b0;
      rd(CODE_VOUT_SET, 16'h1000);
      chk("ceiling on enable", 16'h2100, ceil);
      en = 1'b1;
      $display("test setpoint done");
      snd(CODE_STORE_USER);
      chk("store busy", 16'h0001, {15'h0, busy});
      wr(CODE_VOUT_SET, 16'h0800);
      snd(CODE_RESTORE_USER);
      rd(CODE_VOUT_SET, 16'h1000);
      rd(CODE_SECURITY, 16'h0001);
      wr(CODE_VOUT_SET, 16'h0C00);
      snd(CODE_STORE_DEFAULT);
      wr(CODE_VOUT_SET, 16'h0400);
      snd(CODE_RESTORE_DEFAULT);
      rd(CODE_VOUT_SET, 16'h0C00);
      rd(CODE_SECURITY, 16'h0001);
      $display("test stores done");
      results();
   end
endmodule
